// ### design/uvr_pkg.sv
// Package for the vendor register access path: setup codes, byte positions, limits.
// Assumes both ends share one 50 MHz clock and the same byte-wide register space.
package uvr_pkg;
  // ----------------------------------------------------------------
  // Setup packet codes
  // ----------------------------------------------------------------
  localparam logic [7:0] UVR_TYPE_WRITE = 8'h42;
  localparam logic [7:0] UVR_TYPE_READ = 8'hc2;
  localparam logic [7:0] UVR_REQ_CODE = 8'h33;
  // ----------------------------------------------------------------
  // Setup byte positions (0-based)
  // ----------------------------------------------------------------
  localparam logic [2:0] UVR_POS_TYPE = 3'h0;
  localparam logic [2:0] UVR_POS_REQ = 3'h1;
  localparam logic [2:0] UVR_POS_IDX_LO = 3'h4;
  localparam logic [2:0] UVR_POS_IDX_HI = 3'h5;
  localparam logic [2:0] UVR_POS_LEN_LO = 3'h6;
  localparam logic [2:0] UVR_POS_LAST = 3'h7;
  // ----------------------------------------------------------------
  // Limits and endpoint set
  // ----------------------------------------------------------------
  localparam logic [3:0] UVR_MAX_BYTES = 4'h8;
  localparam logic [3:0] UVR_MIN_BYTES = 4'h1;
  localparam int UVR_NUM_ENDPOINTS = 5;
  localparam int UVR_NUM_CONFIGS = 4;
  localparam logic [3:0] UVR_ALT_STEPS = 4'hf;
  localparam logic [7:0] UVR_RESET_VAL = 8'h00;
endpackage

// ### design/uvr_if.sv
// Interface joining the host end and the device end of the register pipe.
// Assumes a common clock; bytes move on valid and ready, setup first, then data.
`timescale 1ns/1ps
interface uvr_if;
  logic setup_valid;
  logic [7:0] setup_byte;
  logic setup_ready;
  logic out_valid;
  logic [7:0] out_byte;
  logic out_ready;
  logic in_valid;
  logic [7:0] in_byte;
  logic in_ready;
  logic bus_reset;
  modport host (output setup_valid, setup_byte, out_valid, out_byte, in_ready, bus_reset,
                input setup_ready, out_ready, in_valid, in_byte);
  modport dev (input setup_valid, setup_byte, out_valid, out_byte, in_ready, bus_reset,
               output setup_ready, out_ready, in_valid, in_byte);
endinterface

// ### design/uvr_device.sv
// Device end: decodes vendor setup packets and moves 1-8 bytes to or from a byte register file.
// Assumes the host end keeps the packet format; register contents sit outside in user logic.
//
// What the device and host must do
// - Five endpoints, register pipe is endpoint one
// - Video rate 0.5 to 7.5 Mb/s
// - Audio endpoint 64 to 512 kb/s
// - Default descriptors unless EEPROM present
// - Default descriptors offer four configurations
// - Vendor and product id from straps
// - All clocks from one 12 MHz crystal
// - Unused internal clocks switched off
// - Power-on pin and bus reset merged
// - Host applies power-on reset before traffic
// - Alternate settings step video rate 0.5
// - Host writes control, reads status and control
// - Registers byte wide, one byte per address
// - Each request moves one to eight bytes
// - Address increments per further data byte
// - Request type 0x42 writes, 0xC2 reads
// - Request code 0x33 selects register access
// - Start address taken from wIndex bytes
// - Length from low length byte; value bytes and length high byte ignored
// - Write byte n stores at address+n-1
// - Read byte n returns address+n-1
// - Unmapped read completes, data undefined
`timescale 1ns/1ps
module uvr_device
  import uvr_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  uvr_if.dev link,
  input wire logic eeprom_present_i,
  input wire logic [15:0] strap_vendor_id_i,
  input wire logic [15:0] strap_product_id_i,
  input wire logic [3:0] alt_setting_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic reg_we_o,
  output logic reg_re_o,
  output logic [ADDR_W-1:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic int_reset_n_o,
  output logic use_default_desc_o,
  output logic [15:0] vendor_id_o,
  output logic [15:0] product_id_o,
  output logic [3:0] video_step_o,
  output logic video_clk_en_o,
  output logic [2:0] num_configs_o
);
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_addr_w_bad
    $error("ADDR_W must be 1..16");
  end

  // ----------------------------------------------------------------
  // Reset merge
  // ----------------------------------------------------------------
  typedef enum {UVR_S_SETUP, UVR_S_WR, UVR_S_RD_REQ, UVR_S_RD_WAIT, UVR_S_RD_SEND} uvr_state_t;

  logic bus_rst_r;
  logic bus_rst_nxt;
  always_comb begin
    bus_rst_nxt = link.bus_reset;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_rst_r <= 1'b1;
    end else begin
      bus_rst_r <= bus_rst_nxt;
    end
  end
  // Synchronous internal reset avoids gating the async pin with logic
  logic srst;
  assign srst = bus_rst_r;
  assign int_reset_n_o = ~bus_rst_r;

  // ----------------------------------------------------------------
  // Strap capture, descriptors, alternate setting
  // ----------------------------------------------------------------
  // Strap pins pass two flops; no reset, so they fill while reset is held
  logic [32:0] pin_s1_r, pin_s1_nxt, pin_s2_r, pin_s2_nxt;
  always_comb begin
    pin_s1_nxt = {eeprom_present_i, strap_vendor_id_i, strap_product_id_i};
    pin_s2_nxt = pin_s1_r;
  end
  always_ff @(posedge clk_sys_i) begin
    pin_s1_r <= pin_s1_nxt;
    pin_s2_r <= pin_s2_nxt;
  end
  logic [15:0] vid_r, vid_nxt, pid_r, pid_nxt;
  logic dflt_r, dflt_nxt;
  logic [3:0] alt_r, alt_nxt;
  always_comb begin
    vid_nxt = vid_r;
    pid_nxt = pid_r;
    dflt_nxt = dflt_r;
    alt_nxt = alt_r;
    if (srst) begin
      vid_nxt = pin_s2_r[31:16];
      pid_nxt = pin_s2_r[15:0];
      dflt_nxt = ~pin_s2_r[32];
      alt_nxt = 4'h0;
    end else if (alt_setting_i <= UVR_ALT_STEPS) begin
      alt_nxt = alt_setting_i;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vid_r <= 16'h0000;
      pid_r <= 16'h0000;
      dflt_r <= 1'b1;
      alt_r <= 4'h0;
    end else begin
      vid_r <= vid_nxt;
      pid_r <= pid_nxt;
      dflt_r <= dflt_nxt;
      alt_r <= alt_nxt;
    end
  end
  assign vendor_id_o = vid_r;
  assign product_id_o = pid_r;
  assign use_default_desc_o = dflt_r;
  // Step 15 is 7.5 Mb/s, step 1 is 0.5 Mb/s; zero means no video bandwidth
  assign video_step_o = alt_r;
  assign video_clk_en_o = (alt_r != 4'h0);
  assign num_configs_o = dflt_r ? 3'(UVR_NUM_CONFIGS) : 3'h1;

  // ----------------------------------------------------------------
  // Register request engine
  // ----------------------------------------------------------------
  function automatic logic [3:0] clip_len(input logic [7:0] lo);
    if (lo == 8'h00) clip_len = UVR_MIN_BYTES;
    else if (lo > {4'h0, UVR_MAX_BYTES}) clip_len = UVR_MAX_BYTES;
    else clip_len = lo[3:0];
  endfunction

  uvr_state_t st_r, st_nxt;
  logic [2:0] pos_r, pos_nxt;
  logic [7:0] type_r, type_nxt, req_r, req_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [3:0] left_r, left_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic we_r, we_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic [15:0] wa_r, wa_nxt;

  always_comb begin
    st_nxt = st_r;
    pos_nxt = pos_r;
    type_nxt = type_r;
    req_nxt = req_r;
    addr_nxt = addr_r;
    left_nxt = left_r;
    rd_nxt = rd_r;
    we_nxt = 1'b0;
    wd_nxt = wd_r;
    wa_nxt = wa_r;
    case (st_r)
      UVR_S_SETUP: begin
        if (link.setup_valid) begin
          pos_nxt = pos_r + 3'h1;
          case (pos_r)
            UVR_POS_TYPE: type_nxt = link.setup_byte;
            UVR_POS_REQ: req_nxt = link.setup_byte;
            UVR_POS_IDX_LO: addr_nxt[7:0] = link.setup_byte;
            UVR_POS_IDX_HI: addr_nxt[15:8] = link.setup_byte;
            UVR_POS_LEN_LO: left_nxt = clip_len(link.setup_byte);
            default: ; // Value and length high byte are don't-care
          endcase
          if (pos_r == UVR_POS_LAST) begin
            pos_nxt = 3'h0;
            // Foreign requests are dropped silently; other endpoints own them
            if (req_r == UVR_REQ_CODE && type_r == UVR_TYPE_WRITE) begin
              st_nxt = UVR_S_WR;
            end else if (req_r == UVR_REQ_CODE && type_r == UVR_TYPE_READ) begin
              st_nxt = UVR_S_RD_REQ;
            end
          end
        end
      end
      UVR_S_WR: begin
        if (link.out_valid) begin
          we_nxt = 1'b1;
          wd_nxt = link.out_byte;
          wa_nxt = addr_r;
          addr_nxt = addr_r + 16'h0001;
          left_nxt = left_r - 4'h1;
          if (left_r == UVR_MIN_BYTES) st_nxt = UVR_S_SETUP;
        end
      end
      UVR_S_RD_REQ: begin
        // A register file may answer in the strobe cycle itself
        if (reg_rvalid_i) begin
          rd_nxt = reg_rdata_i;
          st_nxt = UVR_S_RD_SEND;
        end else begin
          st_nxt = UVR_S_RD_WAIT;
        end
      end
      UVR_S_RD_WAIT: begin
        // Unmapped addresses still answer; the byte is whatever the bus shows
        if (reg_rvalid_i) begin
          rd_nxt = reg_rdata_i;
          st_nxt = UVR_S_RD_SEND;
        end
      end
      UVR_S_RD_SEND: begin
        if (link.in_ready) begin
          addr_nxt = addr_r + 16'h0001;
          left_nxt = left_r - 4'h1;
          st_nxt = (left_r == UVR_MIN_BYTES) ? UVR_S_SETUP : UVR_S_RD_REQ;
        end
      end
      default: st_nxt = UVR_S_SETUP;
    endcase
    if (srst) begin
      st_nxt = UVR_S_SETUP;
      pos_nxt = 3'h0;
      we_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= UVR_S_SETUP;
      pos_r <= 3'h0;
      type_r <= UVR_RESET_VAL;
      req_r <= UVR_RESET_VAL;
      addr_r <= 16'h0000;
      left_r <= UVR_MIN_BYTES;
      rd_r <= UVR_RESET_VAL;
      we_r <= 1'b0;
      wd_r <= UVR_RESET_VAL;
      wa_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      pos_r <= pos_nxt;
      type_r <= type_nxt;
      req_r <= req_nxt;
      addr_r <= addr_nxt;
      left_r <= left_nxt;
      rd_r <= rd_nxt;
      we_r <= we_nxt;
      wd_r <= wd_nxt;
      wa_r <= wa_nxt;
    end
  end

  assign link.setup_ready = (st_r == UVR_S_SETUP) && !srst;
  assign link.out_ready = (st_r == UVR_S_WR) && !srst;
  assign link.in_valid = (st_r == UVR_S_RD_SEND);
  assign link.in_byte = rd_r;
  assign reg_we_o = we_r;
  assign reg_wdata_o = wd_r;
  assign reg_re_o = (st_r == UVR_S_RD_REQ);
  assign reg_addr_o = we_r ? wa_r[ADDR_W-1:0] : addr_r[ADDR_W-1:0];
  // Endpoints 2..4 datapaths and the crystal PLL live outside this block
endmodule

// ### design/uvr_host.sv
// Host end: turns a user command into a vendor setup packet plus 1-8 data bytes.
// Assumes the device end accepts bytes on ready; one command at a time.
`timescale 1ns/1ps
module uvr_host
  import uvr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  uvr_if.host link,
  input wire logic cmd_valid_i,
  input wire logic cmd_read_i,
  input wire logic [15:0] cmd_addr_i,
  input wire logic [3:0] cmd_len_i,
  input wire logic [63:0] cmd_wdata_i,
  input wire logic bus_reset_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [63:0] rdata_o
);
  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  typedef enum {UVH_IDLE, UVH_SETUP, UVH_WR, UVH_RD, UVH_DONE} uvr_hst_state_t;

  uvr_hst_state_t st_r, st_nxt;
  logic [2:0] pos_r, pos_nxt;
  logic rd_r, rd_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [3:0] len_r, len_nxt, cnt_r, cnt_nxt;
  logic [63:0] wd_r, wd_nxt, rdat_r, rdat_nxt;
  logic [7:0] sb;

  always_comb begin
    case (pos_r)
      UVR_POS_TYPE: sb = rd_r ? UVR_TYPE_READ : UVR_TYPE_WRITE;
      UVR_POS_REQ: sb = UVR_REQ_CODE;
      UVR_POS_IDX_LO: sb = addr_r[7:0];
      UVR_POS_IDX_HI: sb = addr_r[15:8];
      UVR_POS_LEN_LO: sb = {4'h0, len_r};
      default: sb = 8'h00;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    pos_nxt = pos_r;
    rd_nxt = rd_r;
    addr_nxt = addr_r;
    len_nxt = len_r;
    cnt_nxt = cnt_r;
    wd_nxt = wd_r;
    rdat_nxt = rdat_r;
    case (st_r)
      UVH_IDLE: begin
        if (cmd_valid_i) begin
          rd_nxt = cmd_read_i;
          addr_nxt = cmd_addr_i;
          // Out-of-range lengths are clipped so the device never sees them
          len_nxt = (cmd_len_i == 4'h0) ? UVR_MIN_BYTES :
                    (cmd_len_i > UVR_MAX_BYTES) ? UVR_MAX_BYTES : cmd_len_i;
          wd_nxt = cmd_wdata_i;
          rdat_nxt = 64'h0;
          pos_nxt = 3'h0;
          cnt_nxt = 4'h0;
          st_nxt = UVH_SETUP;
        end
      end
      UVH_SETUP: begin
        if (link.setup_ready) begin
          pos_nxt = pos_r + 3'h1;
          if (pos_r == UVR_POS_LAST) st_nxt = rd_r ? UVH_RD : UVH_WR;
        end
      end
      UVH_WR: begin
        if (link.out_ready) begin
          wd_nxt = {8'h00, wd_r[63:8]};
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r + 4'h1 == len_r) st_nxt = UVH_DONE;
        end
      end
      UVH_RD: begin
        if (link.in_valid) begin
          rdat_nxt[cnt_r[2:0]*8 +: 8] = link.in_byte;
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r + 4'h1 == len_r) st_nxt = UVH_DONE;
        end
      end
      UVH_DONE: st_nxt = UVH_IDLE;
      default: st_nxt = UVH_IDLE;
    endcase
    if (bus_reset_i) st_nxt = UVH_IDLE;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= UVH_IDLE;
      pos_r <= 3'h0;
      rd_r <= 1'b0;
      addr_r <= 16'h0000;
      len_r <= UVR_MIN_BYTES;
      cnt_r <= 4'h0;
      wd_r <= 64'h0;
      rdat_r <= 64'h0;
    end else begin
      st_r <= st_nxt;
      pos_r <= pos_nxt;
      rd_r <= rd_nxt;
      addr_r <= addr_nxt;
      len_r <= len_nxt;
      cnt_r <= cnt_nxt;
      wd_r <= wd_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign link.setup_valid = (st_r == UVH_SETUP);
  assign link.setup_byte = sb;
  assign link.out_valid = (st_r == UVH_WR);
  assign link.out_byte = wd_r[7:0];
  assign link.in_ready = (st_r == UVH_RD);
  assign link.bus_reset = bus_reset_i; // Driven straight from bus_reset_i, not gated by power-on reset
  assign cmd_ready_o = (st_r == UVH_IDLE);
  assign done_o = (st_r == UVH_DONE);
  assign rdata_o = rdat_r;
endmodule

// ### verif/uvr_monitor.sv
// Checker for the register pipe between the host end and the device end.
// Assumes it sees the interface signals plus the common clock and reset.
`timescale 1ns/1ps
module uvr_monitor (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic setup_valid_i,
  input wire logic [7:0] setup_byte_i,
  input wire logic setup_ready_i,
  input wire logic out_valid_i,
  input wire logic [7:0] out_byte_i,
  input wire logic out_ready_i,
  input wire logic in_valid_i,
  input wire logic [7:0] in_byte_i,
  input wire logic in_ready_i,
  input wire logic bus_reset_i
);
  // ----------------------------------------------------------------
  // Packet position tracking
  // ----------------------------------------------------------------
  logic [2:0] scnt_r;
  logic [3:0] dcnt_r;
  logic wr_r;
  wire s_take = setup_valid_i && setup_ready_i;
  wire o_take = out_valid_i && out_ready_i;
  wire i_take = in_valid_i && in_ready_i;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scnt_r <= 3'h0;
      dcnt_r <= 4'h0;
      wr_r <= 1'b0;
    end else if (bus_reset_i) begin
      scnt_r <= 3'h0;
      dcnt_r <= 4'h0;
    end else begin
      if (s_take) scnt_r <= scnt_r + 3'h1;
      if (s_take && scnt_r == 3'h0) wr_r <= (setup_byte_i == 8'h42);
      if (s_take && scnt_r == 3'h7) dcnt_r <= 4'h0;
      else if (o_take || i_take) dcnt_r <= dcnt_r + 4'h1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_setup_hold;
    setup_valid_i && !setup_ready_i && !bus_reset_i |=> setup_valid_i && $stable(setup_byte_i);
  endproperty
  a_setup_hold: assert property (p_setup_hold) else $error("setup byte dropped");
  property p_req_type;
    s_take && scnt_r == 3'h0 |-> setup_byte_i == 8'h42 || setup_byte_i == 8'hc2;
  endproperty
  a_req_type: assert property (p_req_type) else $error("bad request type");
  property p_req_code;
    s_take && scnt_r == 3'h1 |-> setup_byte_i == 8'h33;
  endproperty
  a_req_code: assert property (p_req_code) else $error("bad request code");
  property p_out_dir;
    o_take |-> wr_r && scnt_r == 3'h0 && dcnt_r < 4'h8;
  endproperty
  a_out_dir: assert property (p_out_dir) else $error("write byte misplaced");
  property p_in_dir;
    i_take |-> !wr_r && scnt_r == 3'h0 && dcnt_r < 4'h8;
  endproperty
  a_in_dir: assert property (p_in_dir) else $error("read byte misplaced");
  property p_out_hold;
    out_valid_i && !out_ready_i && !bus_reset_i |=> out_valid_i && $stable(out_byte_i);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("write byte dropped");
  property p_in_hold;
    in_valid_i && !in_ready_i && !bus_reset_i |=> in_valid_i && $stable(in_byte_i);
  endproperty
  a_in_hold: assert property (p_in_hold) else $error("read byte dropped");
  property p_bus_rst;
    bus_reset_i |=> !setup_ready_i;
  endproperty
  a_bus_rst: assert property (p_bus_rst) else $error("ready during bus reset");
endmodule

// ### verif/usb_vendor_register_access_bench.sv
// Bench joining host end and device end; models a 64-byte register file.
// Assumes one 50 MHz clock; the bench drives commands, straps and alt setting.
`timescale 1ns/1ps
module usb_vendor_register_access_bench;
  import uvr_pkg::*;
  logic clk_sys_i, rst_n_i, cmd_valid_i, cmd_read_i, bus_reset_i, cmd_ready_o, done_o;
  logic [15:0] cmd_addr_i, strap_vendor_id_i, strap_product_id_i;
  logic [15:0] vendor_id_o, product_id_o, reg_addr_o;
  logic [3:0] cmd_len_i, alt_setting_i, video_step_o;
  logic [63:0] cmd_wdata_i, rdata_o;
  logic eeprom_present_i, reg_rvalid_i, reg_we_o, reg_re_o, int_reset_n_o;
  logic use_default_desc_o, video_clk_en_o;
  logic [7:0] reg_rdata_i, reg_wdata_o;
  logic [2:0] num_configs_o;
  logic [7:0] mem [0:63];
  logic [7:0] shadow [0:63];
  int num_errors = 0;
  int cmp_count = 0;
  uvr_if link_if ();
  uvr_host uvr_host_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(link_if),
    .cmd_valid_i(cmd_valid_i), .cmd_read_i(cmd_read_i), .cmd_addr_i(cmd_addr_i),
    .cmd_len_i(cmd_len_i), .cmd_wdata_i(cmd_wdata_i), .bus_reset_i(bus_reset_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .rdata_o(rdata_o));
  uvr_device uvr_device_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(link_if),
    .eeprom_present_i(eeprom_present_i), .strap_vendor_id_i(strap_vendor_id_i),
    .strap_product_id_i(strap_product_id_i), .alt_setting_i(alt_setting_i),
    .reg_rdata_i(reg_rdata_i), .reg_rvalid_i(reg_rvalid_i), .reg_we_o(reg_we_o),
    .reg_re_o(reg_re_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
    .int_reset_n_o(int_reset_n_o), .use_default_desc_o(use_default_desc_o),
    .vendor_id_o(vendor_id_o), .product_id_o(product_id_o), .video_step_o(video_step_o),
    .video_clk_en_o(video_clk_en_o), .num_configs_o(num_configs_o));
  uvr_monitor uvr_monitor_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .setup_valid_i(link_if.setup_valid), .setup_byte_i(link_if.setup_byte),
    .setup_ready_i(link_if.setup_ready), .out_valid_i(link_if.out_valid),
    .out_byte_i(link_if.out_byte), .out_ready_i(link_if.out_ready),
    .in_valid_i(link_if.in_valid), .in_byte_i(link_if.in_byte),
    .in_ready_i(link_if.in_ready), .bus_reset_i(link_if.bus_reset));
  // ----------------------------------------------------------------
  // Register file on the device's user side; unmapped reads give junk
  // ----------------------------------------------------------------
  assign reg_rvalid_i = reg_re_o;
  assign reg_rdata_i = (reg_addr_o < 16'h0040) ? mem[reg_addr_o[5:0]] : 8'ha5;
  always @(posedge clk_sys_i) begin
    if (reg_we_o === 1'b1 && reg_addr_o < 16'h0040) mem[reg_addr_o[5:0]] <= reg_wdata_o;
  end
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic run_cmd(input logic rd, input logic [15:0] a, input logic [3:0] n,
                         input logic [63:0] wd);
    int k;
    k = 0;
    @(negedge clk_sys_i);
    while (cmd_ready_o !== 1'b1 && k < 100) begin
      @(negedge clk_sys_i);
      k++;
    end
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b1;
    cmd_read_i <= rd;
    cmd_addr_i <= a;
    cmd_len_i <= n;
    cmd_wdata_i <= wd;
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    k = 0;
    @(negedge clk_sys_i);
    while (done_o !== 1'b1 && k < 300) begin
      @(negedge clk_sys_i);
      k++;
    end
    check("done", {63'h0, done_o}, 64'h1);
  endtask
  task automatic wr(input logic [15:0] a, input logic [3:0] n, input logic [63:0] wd);
    run_cmd(1'b0, a, n, wd);
    for (int i = 0; i < n; i++) shadow[6'(a + 16'(i))] = wd[8*i +: 8];
  endtask
  task automatic rd(input logic [15:0] a, input logic [3:0] n);
    logic [63:0] exp;
    logic [63:0] m;
    exp = 64'h0;
    m = (n == 4'h8) ? '1 : ((64'h1 << (8 * n)) - 64'h1);
    run_cmd(1'b1, a, n, 64'h0);
    for (int i = 0; i < n; i++) exp[8*i +: 8] = shadow[6'(a + 16'(i))];
    check("read data", rdata_o & m, exp);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_idle();
    check("vendor", 64'(vendor_id_o), 64'h1234);
    check("product", 64'(product_id_o), 64'h5678);
    check("default desc", 64'(use_default_desc_o), 64'h1);
    check("configs", 64'(num_configs_o), 64'(UVR_NUM_CONFIGS));
    $display("t_idle done");
  endtask
  task automatic t_alt();
    for (int s = 0; s < 16; s++) begin
      @(posedge clk_sys_i);
      alt_setting_i <= 4'(s);
      repeat (3) @(negedge clk_sys_i);
      check("video step", 64'(video_step_o), 64'(s));
      check("video clk", 64'(video_clk_en_o), 64'(s != 0));
    end
    $display("t_alt done");
  endtask
  task automatic t_burst();
    wr(16'h000a, 4'h8, 64'h8877665544332211);
    rd(16'h000a, 4'h8);
    wr(16'h0014, 4'h3, 64'h0000000000c3b2a1);
    rd(16'h0013, 4'h5);
    wr(16'h003f, 4'h1, 64'h00000000000000e7);
    rd(16'h003e, 4'h2);
    $display("t_burst done");
  endtask
  task automatic t_unmapped();
    run_cmd(1'b1, 16'h0200, 4'h4, 64'h0);
    rd(16'h000c, 4'h2);
    $display("t_unmapped done");
  endtask
  task automatic t_len_clip();
    // Length zero moves one byte; lengths above eight move eight
    run_cmd(1'b0, 16'h0020, 4'h0, 64'h000000000000005a);
    shadow[6'h20] = 8'h5a;
    rd(16'h0020, 4'h1);
    run_cmd(1'b0, 16'h0028, 4'hf, 64'hf0e0d0c0b0a09080);
    for (int i = 0; i < 8; i++) shadow[6'(16'h0028 + 16'(i))] = 8'h80 + 8'(16 * i);
    rd(16'h0029, 4'h8);
    $display("t_len_clip done");
  endtask
  task automatic t_bus_reset();
    @(posedge clk_sys_i);
    eeprom_present_i <= 1'b1;
    strap_vendor_id_i <= 16'h9abc;
    bus_reset_i <= 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check("int reset", 64'(int_reset_n_o), 64'h0);
    @(posedge clk_sys_i);
    bus_reset_i <= 1'b0;
    repeat (3) @(negedge clk_sys_i);
    check("int reset off", 64'(int_reset_n_o), 64'h1);
    check("eeprom desc", 64'(use_default_desc_o), 64'h0);
    check("vendor new", 64'(vendor_id_o), 64'h9abc);
    rd(16'h000a, 4'h8);
    $display("t_bus_reset done");
  endtask
  initial begin
    rst_n_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_read_i = 1'b0;
    cmd_addr_i = 16'h0;
    cmd_len_i = 4'h1;
    cmd_wdata_i = 64'h0;
    bus_reset_i = 1'b0;
    eeprom_present_i = 1'b0;
    // Strap values are arbitrary
    strap_vendor_id_i = 16'h1234;
    strap_product_id_i = 16'h5678;
    alt_setting_i = 4'h0;
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'(i) ^ 8'h3c;
      shadow[i] = 8'(i) ^ 8'h3c;
    end
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (2) @(negedge clk_sys_i);
    t_idle();
    t_alt();
    t_burst();
    t_unmapped();
    t_len_clip();
    t_bus_reset();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    test_done();
  end
endmodule
